//--- core/sram_access_defines.svh
// Purpose: Widths and counts shared by the pipelined burst memory files.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef SRAM_ACCESS_DEFINES_SVH
`define SRAM_ACCESS_DEFINES_SVH

`define ADDR_W 19
`define BURST_W 2
`define LANES 4
`define BYTE_W 8
`define DATA_W 32
`define WORD_W 36
`define BUF_DEPTH 2
`define ALL_LANES_OFF 4'hf
`define SLEEP_CYC 2'h2

`endif

//--- core/sram_access_pkg.sv
// Purpose: Types and the byte-lane merge shared by the memory files.
// Assumes: Word layout is {parity[3:0], data[31:0]}.
// Notes:   Lane i owns data byte i and parity bit i.
`include "sram_access_defines.svh"

package sram_access_pkg;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b001,
        OP_READ  = 3'b010,
        OP_WRITE = 3'b100
    } op_t;

    typedef enum logic [3:0] {
        SL_AWAKE  = 4'b0001,
        SL_ENTER  = 4'b0010,
        SL_ASLEEP = 4'b0100,
        SL_LEAVE  = 4'b1000
    } sleep_t;

    function automatic logic [`WORD_W-1:0] lane_merge(
        input logic [`WORD_W-1:0] old_w,
        input logic [`LANES-1:0]  act,
        input logic [`WORD_W-1:0] new_w
    );
        logic [`WORD_W-1:0] w;
        w = old_w;
        for (int i = 0; i < `LANES; i++) begin
            if (act[i]) begin
                w[`BYTE_W*i +: `BYTE_W] = new_w[`BYTE_W*i +: `BYTE_W];
                w[`DATA_W+i]            = new_w[`DATA_W+i];
            end
        end
        return w;
    endfunction

endpackage

//--- core/wr_buffer.sv
// Purpose: Two-entry shift buffer with valid and ready on both sides.
// Assumes: Slot 0 is always the oldest entry.
// Notes:   Every slot is visible so the reader can forward pending words.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_defines.svh"

module wr_buffer
    import sram_access_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `BUF_DEPTH
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Filling side
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [WIDTH-1:0]       in_data,
    // Draining side
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [WIDTH-1:0]            out_data,
    // Slot view, oldest first
    output logic [DEPTH*WIDTH-1:0]      peek_data,
    output logic [DEPTH-1:0]            peek_valid
);

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [CW-1:0]               count;
    } buf_state_t;

    buf_state_t st_r;
    buf_state_t st_nxt;
    logic       push;
    logic       pop;
    logic [CW-1:0] fill;

    assign in_ready  = st_r.count < CW'(DEPTH);
    assign out_valid = st_r.count != '0;
    assign out_data  = st_r.slot[0];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        fill   = st_r.count - CW'(pop);
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_nxt.slot[i] = st_r.slot[i+1];
            end
        end
        if (push) begin
            st_nxt.slot[fill] = in_data;
        end
        st_nxt.count = fill + CW'(push);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_peek
        assign peek_data[g*WIDTH +: WIDTH] = st_r.slot[g];
        assign peek_valid[g]               = CW'(g) < st_r.count;
    end

endmodule

`default_nettype wire

//--- core/sram_array.sv
// Purpose: Single-port storage array with per-lane writes.
// Assumes: Read is combinational from the presented address.
// Notes:   No reset; contents survive sleep.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_defines.svh"

module sram_array
    import sram_access_pkg::*;
(
    // Clock
    input  wire logic                 clk,
    // Port
    input  wire logic                 wr_en,
    input  wire logic [`LANES-1:0]    wr_lanes,
    input  wire logic [`ADDR_W-1:0]   addr,
    input  wire logic [`WORD_W-1:0]   wr_data,
    output logic [`WORD_W-1:0]        rd_data
);

    logic [`WORD_W-1:0] mem [0:(1<<`ADDR_W)-1];

    assign rd_data = mem[addr];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= lane_merge(mem[addr], wr_lanes, wr_data);
        end
    end

endmodule

`default_nettype wire

//--- core/burst_sram.sv
// Purpose: Pin-level logic of a pipelined burst static memory.
// Assumes: All command pins are synchronous to ref_clk.
// Notes:   Reads return one edge after the command, writes take data two
//          edges after it; no idle cycle is needed between operations.
//
// Notes on behaviour
// - Read loads address when qualified, all selects active, write high, load.
// - Read word leaves the output register after the next clock rise.
// - Read data is driven only while output enable is low.
// - A new command is accepted in the cycle after a read.
// - Deselect is pipelined; outputs float after the following rise.
// - Burst counter steps through four addresses from one loaded address, then wraps while advance stays high.
// - Burst order pin low is linear, high or floating is interleaved.
// - Counter touches only the two low address bits and wraps there.
// - Advance high steps the counter and ignores selects and write select.
// - Direction is latched at burst start and kept while continuing.
// - Write loads address and lane controls at a qualified selected rise.
// - Rise after a write command floats data and parity outputs.
// - Write data is taken at the second rise after the command.
// - Advance high during a burst write increments the counter.
// - Sleep keeps contents; entry and exit each take two cycles.
// - Accesses pending at sleep entry are dropped as invalid.
// - Interleaved address is start XOR step count.
// - Linear address is start plus step count, modulo four.
// - Clock qualify high holds the command pipeline and output word as a wait state; queued writes still drain.
// - After power-up the memory is deselected with outputs floating.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_defines.svh"

module burst_sram
    import sram_access_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    // Command pins
    input  wire logic [`ADDR_W-1:0]   addr,
    input  wire logic                 clock_qualify_n,
    input  wire logic                 chip_sel_first_n,
    input  wire logic                 chip_sel_second,
    input  wire logic                 chip_sel_third_n,
    input  wire logic                 write_sel_n,
    input  wire logic                 advance_or_load,
    input  wire logic [`LANES-1:0]    byte_lane_write_n,
    input  wire logic                 burst_order,
    // Asynchronous pins
    input  wire logic                 out_enable_n,
    input  wire logic                 sleep_request,
    // Data pins
    input  wire logic [`DATA_W-1:0]   data_in,
    output logic [`DATA_W-1:0]        data_out,
    output logic                      data_oe,
    input  wire logic [`LANES-1:0]    parity_in,
    output logic [`LANES-1:0]         parity_out,
    output logic                      parity_oe
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------

    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    localparam int PW = `ADDR_W + `LANES + `WORD_W;
    localparam int HW = `ADDR_W - `BURST_W;

    typedef struct packed {
        logic [HW-1:0]       addr_hi;
        logic [`BURST_W-1:0] start;
        logic [`BURST_W-1:0] step;
        logic                live;
        logic                dir_wr;
        op_t                 s1_op;
        logic [`ADDR_W-1:0]  s1_addr;
        logic [`LANES-1:0]   s1_lanes;
        logic                s2_wr;
        logic [`ADDR_W-1:0]  s2_addr;
        logic [`LANES-1:0]   s2_lanes;
        logic                out_valid;
        logic [`WORD_W-1:0]  out_word;
        sleep_t              sl;
        logic [1:0]          sl_cnt;
    } state_t;

    state_t st;
    state_t nxt;

    logic                   go;
    logic                   sel;
    logic                   port_read;
    logic [`BURST_W-1:0]    step_inc;
    logic [`BURST_W-1:0]    next_low;
    logic                   buf_in_valid;
    logic                   buf_in_ready;
    logic [PW-1:0]          buf_in_data;
    logic                   buf_out_valid;
    logic                   buf_out_ready;
    logic [PW-1:0]          buf_out_data;
    logic [2*PW-1:0]        peek_data;
    logic [1:0]             peek_valid;
    logic [`ADDR_W-1:0]     port_addr;
    logic [`WORD_W-1:0]     core_word;
    logic [`WORD_W-1:0]     read_word;
    logic [`WORD_W-1:0]     in_word;
    logic                   drive;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------

    // Wait state.
    // Sleep and its request block every synchronous command.
    assign go  = !clock_qualify_n && st.sl == SL_AWAKE && !sleep_request;
    assign sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;

    assign step_inc = st.step + 2'h1;

    assign next_low = burst_order ? (st.start ^ step_inc) : (st.start + step_inc);

    assign in_word = {parity_in, data_in};

    // ------------------------------------------------------------
    // Write buffer and array port
    // ------------------------------------------------------------

    // Data taken second rise.
    // A write whose lanes are all off stores nothing and is not queued.
    assign buf_in_valid = go && st.s2_wr && (st.s2_lanes != '0);
    assign buf_in_data  = {st.s2_addr, st.s2_lanes, in_word};

    // Reads own the single port; queued writes drain in the gaps. Two
    // entries cover the worst read/write mix, so a full buffer never
    // meets another arriving word.
    assign port_read     = go && st.s1_op == OP_READ;
    assign buf_out_ready = !port_read;
    assign port_addr     = port_read ? st.s1_addr : buf_out_data[PW-1 -: `ADDR_W];

    wr_buffer #(
        .WIDTH (PW),
        .DEPTH (`BUF_DEPTH)
    ) u_wr_buffer (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .in_valid   (buf_in_valid && buf_in_ready),
        .in_ready   (buf_in_ready),
        .in_data    (buf_in_data),
        .out_valid  (buf_out_valid),
        .out_ready  (buf_out_ready),
        .out_data   (buf_out_data),
        .peek_data  (peek_data),
        .peek_valid (peek_valid)
    );

    sram_array u_sram_array (
        .clk      (ref_clk),
        .wr_en    (buf_out_valid && buf_out_ready),
        .wr_lanes (buf_out_data[`WORD_W +: `LANES]),
        .addr     (port_addr),
        .wr_data  (buf_out_data[`WORD_W-1:0]),
        .rd_data  (core_word)
    );

    // Pending writes to the read address are merged oldest first, so a
    // read right behind a write sees the new bytes.
    always_comb begin
        read_word = core_word;
        for (int i = 0; i < `BUF_DEPTH; i++) begin
            if (peek_valid[i] && peek_data[i*PW+`WORD_W+`LANES +: `ADDR_W] == st.s1_addr) begin
                read_word = lane_merge(read_word, peek_data[i*PW+`WORD_W +: `LANES],
                                       peek_data[i*PW +: `WORD_W]);
            end
        end
        if (buf_in_valid && st.s2_addr == st.s1_addr) begin
            read_word = lane_merge(read_word, st.s2_lanes, in_word);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        nxt = st;
        if (go) begin
            nxt.s2_wr    = st.s1_op == OP_WRITE;
            nxt.s2_addr  = st.s1_addr;
            nxt.s2_lanes = st.s1_lanes;
            nxt.out_valid = st.s1_op == OP_READ;
            if (st.s1_op == OP_READ) begin
                nxt.out_word = read_word;
            end
            if (advance_or_load) begin
                // Four addresses from one, then wraps.
                if (st.live) begin
                    nxt.step     = step_inc;
                    nxt.s1_op    = st.dir_wr ? OP_WRITE : OP_READ;
                    nxt.s1_addr  = {st.addr_hi, next_low};
                    nxt.s1_lanes = ~byte_lane_write_n;
                end else begin
                    nxt.s1_op = OP_NONE;
                end
            end else if (sel) begin
                nxt.addr_hi  = addr[`ADDR_W-1:`BURST_W];
                nxt.start    = addr[`BURST_W-1:0];
                nxt.step     = 2'h0;
                nxt.live     = 1'b1;
                nxt.dir_wr   = !write_sel_n;
                nxt.s1_op    = write_sel_n ? OP_READ : OP_WRITE;
                nxt.s1_addr  = addr;
                nxt.s1_lanes = ~byte_lane_write_n;
            end else begin
                nxt.live  = 1'b0;
                nxt.s1_op = OP_NONE;
            end
        end

        unique case (st.sl)
            SL_AWAKE: begin
                if (sleep_request) begin
                    nxt.sl     = SL_ENTER;
                    nxt.sl_cnt = 2'h0;
                    nxt.s1_op     = OP_NONE;
                    nxt.s2_wr     = 1'b0;
                    nxt.out_valid = 1'b0;
                    nxt.live      = 1'b0;
                end
            end
            SL_ENTER: begin
                if (!sleep_request) begin
                    nxt.sl     = SL_LEAVE;
                    nxt.sl_cnt = 2'h0;
                end else if (st.sl_cnt == `SLEEP_CYC - 2'h1) begin
                    nxt.sl = SL_ASLEEP;
                end else begin
                    nxt.sl_cnt = st.sl_cnt + 2'h1;
                end
            end
            SL_ASLEEP: begin
                if (!sleep_request) begin
                    nxt.sl     = SL_LEAVE;
                    nxt.sl_cnt = 2'h0;
                end
            end
            SL_LEAVE: begin
                if (sleep_request) begin
                    nxt.sl     = SL_ENTER;
                    nxt.sl_cnt = 2'h0;
                end else if (st.sl_cnt == `SLEEP_CYC - 2'h1) begin
                    nxt.sl = SL_AWAKE;
                end else begin
                    nxt.sl_cnt = st.sl_cnt + 2'h1;
                end
            end
            default: begin
                nxt.sl = SL_AWAKE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.s1_op <= OP_NONE;
            st.sl    <= SL_AWAKE;
        end else begin
            st <= nxt;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------

    // Quiet while asleep.
    // Output enable acts without the clock, so the drive follows the pin.
    assign drive      = st.out_valid && !out_enable_n && st.sl == SL_AWAKE;
    assign data_oe    = drive;
    assign parity_oe  = drive;
    assign data_out   = st.out_word[`DATA_W-1:0];
    assign parity_out = st.out_word[`WORD_W-1:`DATA_W];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!rst_n);

    sequence s_read_cmd;
        go && !advance_or_load && sel && write_sel_n;
    endsequence

    sequence s_write_cmd;
        go && !advance_or_load && sel && !write_sel_n;
    endsequence

    sequence s_burst_step;
        go && advance_or_load && st.live;
    endsequence

    a_read_drive: assert property (
        s_read_cmd ##1 go |=> st.out_valid && (data_oe == !out_enable_n))
        else $error("read word not on the bus after the next rise");

    a_deselect_float: assert property (
        go && !advance_or_load && !sel ##1 go |=> !data_oe && !parity_oe)
        else $error("outputs still driven after a deselect");

    a_write_release: assert property (
        s_write_cmd ##1 go |=> !data_oe && !parity_oe)
        else $error("outputs driven in the write data phase");

    a_write_capture: assert property (
        (s_write_cmd and (byte_lane_write_n != `ALL_LANES_OFF)) ##1 go ##1 go
        |-> buf_in_valid && buf_in_data[PW-1 -: `ADDR_W] == $past(addr, 2))
        else $error("write data not taken at the second rise");

    a_burst_linear: assert property (
        (s_burst_step and !burst_order)
        |=> st.s1_addr[1:0] == 2'($past(st.s1_addr[1:0]) + 2'h1))
        else $error("linear burst address out of order");

    a_burst_inter: assert property (
        (s_burst_step and burst_order)
        |=> st.s1_addr[1:0] == (st.start ^ st.step)
            && st.step == 2'($past(st.step) + 2'h1))
        else $error("interleaved burst address out of order");

    a_burst_dir: assert property (
        s_burst_step |=> st.s1_op == (st.dir_wr ? OP_WRITE : OP_READ)
            && $stable(st.addr_hi))
        else $error("burst changed direction or upper address");

    a_stall_hold: assert property (
        clock_qualify_n && st.sl == SL_AWAKE && !sleep_request
        |=> $stable(st.s1_op) && $stable(st.out_word) && $stable(st.step))
        else $error("state moved during a wait state");

    a_sleep_entry: assert property (
        st.sl == SL_AWAKE && sleep_request ##1 sleep_request[*2]
        |=> st.sl == SL_ASLEEP)
        else $error("sleep not reached after two cycles");

    a_sleep_exit: assert property (
        st.sl == SL_ASLEEP && !sleep_request ##1 !sleep_request[*2]
        |=> st.sl == SL_AWAKE)
        else $error("sleep not left after two cycles");

    a_sleep_quiet: assert property (
        st.sl != SL_AWAKE |-> !data_oe && st.s1_op == OP_NONE)
        else $error("activity while sleeping");

endmodule

`default_nettype wire

//--- sim/ctrl_model.sv
// Purpose: Behavioural memory controller that drives the pin bus.
// Assumes: Each call starts just after a rising edge of ref_clk.
// Notes:   Idle data, and outside a wait state unneeded address and write select, show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_defines.svh"

module ctrl_model (
    // Clock and memory drive state
    input  wire logic               ref_clk,
    input  wire logic               data_oe,
    // Command pins
    output logic [`ADDR_W-1:0]      addr,
    output logic                    clock_qualify_n,
    output logic                    chip_sel_first_n,
    output logic                    chip_sel_second,
    output logic                    chip_sel_third_n,
    output logic                    write_sel_n,
    output logic                    advance_or_load,
    output logic [`LANES-1:0]       byte_lane_write_n,
    output logic                    burst_order,
    // Asynchronous pins
    output logic                    out_enable_n,
    output logic                    sleep_request,
    // Write data
    output logic [`DATA_W-1:0]      data_in,
    output logic [`LANES-1:0]       parity_in
);
    // -----------------------------------------------------------------
    // Idle levels and one bus cycle
    // -----------------------------------------------------------------
    initial begin
        addr = '0;
        clock_qualify_n = 1'b0;
        chip_sel_first_n = 1'b1;
        chip_sel_second = 1'b1;
        chip_sel_third_n = 1'b0;
        write_sel_n = 1'b1;
        advance_or_load = 1'b0;
        byte_lane_write_n = 4'hf;
        burst_order = 1'b1;
        out_enable_n = 1'b0;
        sleep_request = 1'b0;
        {parity_in, data_in} = '0;
    end

    // Kinds: 0 deselect, 1 read, 2 write, 3 advance, 4 wait state.
    task automatic cmd(input logic [2:0] kind, input logic [`ADDR_W-1:0] a,
                       input logic [`LANES-1:0] ln, input logic wd_on,
                       input logic [`WORD_W-1:0] wd);
        clock_qualify_n = (kind == 3'h4);
        // lane selects driven in every cycle.
        byte_lane_write_n = ln;
        if (kind == 3'h1 || kind == 3'h2) begin
            addr = a;
            chip_sel_first_n = 1'b0;
            write_sel_n = (kind == 3'h1);
            advance_or_load = 1'b0;
        end else if (kind != 3'h4) begin
            addr = ~addr;
            chip_sel_first_n = 1'b1;
            advance_or_load = (kind == 3'h3);
            write_sel_n = ~write_sel_n;
        end
        // data only in its phase, never against the memory.
        if (wd_on && !data_oe) begin
            {parity_in, data_in} = wd;
        end else begin
            {parity_in, data_in} = ~{parity_in, data_in};
        end
        @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

//--- sim/burst_sram_tb.sv
// Purpose: Self-checking bench for the pipelined burst memory.
// Assumes: Controller model drives every pin just after each rising edge.
// Notes:   Words are checked as {parity, data}.
`timescale 1ns/1ps
`default_nettype none
`include "sram_access_defines.svh"

module burst_sram_tb;
    localparam logic [2:0] DES = 3'h0, RD = 3'h1, WR = 3'h2, ADV = 3'h3, STL = 3'h4;
    localparam logic [`ADDR_W-1:0] BASE = 19'h000a4;
    logic ref_clk, nrst, clock_qualify_n, chip_sel_first_n, chip_sel_second;
    logic chip_sel_third_n, write_sel_n, advance_or_load, burst_order;
    logic out_enable_n, sleep_request, data_oe, parity_oe;
    logic [`ADDR_W-1:0] addr;
    logic [`LANES-1:0] byte_lane_write_n, parity_in, parity_out;
    logic [`DATA_W-1:0] data_in, data_out;
    int bad_count;
    int checked;

    burst_sram u_burst_sram (.ref_clk, .nrst, .addr, .clock_qualify_n,
        .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .write_sel_n,
        .advance_or_load, .byte_lane_write_n, .burst_order, .out_enable_n,
        .sleep_request, .data_in, .data_out, .data_oe, .parity_in,
        .parity_out, .parity_oe);
    ctrl_model u_ctrl_model (.ref_clk, .data_oe, .addr, .clock_qualify_n,
        .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n, .write_sel_n,
        .advance_or_load, .byte_lane_write_n, .burst_order, .out_enable_n,
        .sleep_request, .data_in, .parity_in);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [`WORD_W-1:0] word(input int i);
        return {i[3:0], 32'ha5a5_0000 + i[31:0]};
    endfunction

    task automatic check(input string what, input logic [`WORD_W-1:0] seen,
                         input logic [`WORD_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic op(input logic [2:0] k, input logic [`ADDR_W-1:0] a);
        u_ctrl_model.cmd(k, a, 4'h0, 1'b0, '0);
    endtask

    task automatic opd(input logic [2:0] k, input logic [`WORD_W-1:0] wd);
        u_ctrl_model.cmd(k, BASE, 4'h0, 1'b1, wd);
    endtask

    task automatic oe(input logic e);
        check("output enable", {34'h0, data_oe, parity_oe}, {34'h0, e, e});
    endtask

    task automatic see(input int i);
        check("read word", {parity_out, data_out}, word(i));
        oe(1'b1);
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        oe(1'b0);
        repeat (3) op(DES, BASE);
    endtask

    task automatic t_burst_write;
        op(WR, BASE);
        op(ADV, BASE);
        opd(ADV, word(0));
        opd(ADV, word(1));
        opd(DES, word(2));
        opd(DES, word(3));
    endtask

    task automatic t_burst_read(input logic ord, input logic [1:0] st);
        logic [1:0] idx;
        u_ctrl_model.burst_order = ord;
        op(RD, BASE | {17'h0, st});
        for (int i = 0; i < 4; i++) begin
            op(i < 3 ? ADV : DES, BASE);
            idx = ord ? st ^ i[1:0] : st + i[1:0];
            see(idx);
        end
        op(DES, BASE);
        oe(1'b0);
    endtask

    task automatic t_lanes;
        logic [`WORD_W-1:0] exp;
        exp = word(0);
        exp[7:0] = 8'hff;
        exp[32] = 1'b1;
        op(RD, BASE + 1);
        u_ctrl_model.cmd(WR, BASE, 4'he, 1'b0, '0);
        see(1);
        op(DES, BASE);
        oe(1'b0);
        opd(DES, '1);
        op(RD, BASE);
        op(RD, BASE + 3);
        check("lane merge", {parity_out, data_out}, exp);
        op(DES, BASE);
        see(3);
    endtask

    task automatic t_stall;
        op(RD, BASE + 1);
        op(RD, BASE + 2);
        repeat (3) begin
            op(STL, BASE);
            see(1);
        end
        u_ctrl_model.out_enable_n = 1'b1;
        #1;
        oe(1'b0);
        u_ctrl_model.out_enable_n = 1'b0;
        op(DES, BASE);
        see(2);
    endtask

    task automatic t_sleep;
        u_ctrl_model.sleep_request = 1'b1;
        repeat (3) op(DES, BASE);
        op(RD, BASE + 3);
        op(DES, BASE);
        oe(1'b0);
        u_ctrl_model.sleep_request = 1'b0;
        repeat (3) op(DES, BASE);
        op(RD, BASE + 3);
        op(DES, BASE);
        see(3);
    endtask

    // -----------------------------------------------------------------
    // Run control
    // -----------------------------------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // The whole run is under a hundred cycles, so this only cuts a hang.
    initial begin
        #(25 * 2000);
        bad_count++;
        stop_test;
    end

    initial begin
        bad_count = 0;
        checked = 0;
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        t_reset;
        t_burst_write;
        t_burst_read(1'b0, 2'h1);
        t_burst_read(1'b1, 2'h2);
        t_lanes;
        t_stall;
        t_sleep;
        stop_test;
    end
endmodule
`default_nettype wire
